// ### bench/cst_card_model.sv
`timescale 1ns/10ps
module cst_card_model
(
  input wire logic clk,
  input wire logic inserted,
  input wire logic contact,
  input wire logic pullup_on_n,
  input wire logic pulldown_on,
  input wire logic [1:0] supply_select,
  input wire logic deactivate,
  input wire logic good,
  input wire logic [1:0] lag,
  input wire logic fault,
  output logic card_sense_pin,
  output logic supply_ok,
  output logic supply_fault
);
  logic on = 1'b0;
  logic [3:0] ramp = 4'h0;
  logic wob = 1'b0;
  always @(posedge clk)
  begin
    on <= !deactivate && (on || supply_select != 2'b00);
    ramp <= {ramp[2:0], on && good};
    wob <= !wob;
  end
  assign supply_ok = ramp[lag];
  assign supply_fault = fault;
  assign card_sense_pin = inserted ? contact : !pullup_on_n ? 1'b1 : pulldown_on ? 1'b0 : wob;
endmodule : cst_card_model

// ### bench/cst_top_bench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module cst_top_bench;
  localparam int DB = 4;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tick_32k = 1'b0;
  logic tick_1k = 1'b0;
  logic ins = 1'b0;
  logic con = 1'b0;
  logic good = 1'b0;
  logic [1:0] lag = 2'b11;
  logic fault = 1'b0;
  logic [7:0] reg_rdata, q;
  logic [1:0] supply_select;
  logic supply_ok, supply_fault, card_sense_pin, activation_go, deactivate;
  logic card_present, card_event_irq, pullup_on_n, pulldown_on;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  int nd = 0;
  int t0, n;
  initial
  begin
    forever #5 clk = ~clk;
  end
  // ticks scaled down to keep the run short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    tick_32k <= cyc % 8 == 7;
    tick_1k <= cyc % 16 == 15;
    if (deactivate === 1'b1)
      nd <= nd + 1;
    if (cyc == 4000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  cst_top #(.DEBOUNCE_TICKS(DB)) cst_top_inst (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tick_32k(tick_32k), .tick_1k(tick_1k),
    .supply_ok(supply_ok), .supply_fault(supply_fault), .card_sense_pin(card_sense_pin),
    .supply_select(supply_select), .activation_go(activation_go), .deactivate(deactivate),
    .card_present(card_present), .card_event_irq(card_event_irq), .pullup_on_n(pullup_on_n),
    .pulldown_on(pulldown_on));
  cst_card_model cst_card_model_inst (
    .clk(clk), .inserted(ins), .contact(con), .pullup_on_n(pullup_on_n), .good(good),
    .pulldown_on(pulldown_on), .supply_select(supply_select), .deactivate(deactivate),
    .lag(lag), .fault(fault), .card_sense_pin(card_sense_pin), .supply_ok(supply_ok),
    .supply_fault(supply_fault));
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic tk(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tk
  task automatic w(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : w
  task automatic r(input logic [15:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    tk(0);
    q = reg_rdata;
  endtask : r
  task automatic t_regs();
    r(16'hFE04);
    `CHK("timing", 8'h0F, q)
    r(16'hFE00);
    `CHK("unmapped", 8'h00, q)
    w(16'hFE05, 8'h01);
    r(16'hFE05);
    `CHK("detect", 8'h00, q)
  endtask : t_regs
  task automatic t_det(input logic p);
    logic [7:0] c;
    c = p ? 8'h0E : 8'h00;
    @(posedge clk) con <= p;
    w(16'hFE05, c);
    w(16'hFE05, c | 8'h40);
    tk(3);
    `CHK("pull", c[2:1], {pullup_on_n, pulldown_on})
    @(posedge clk) ins <= 1'b1;
    tk(2);
    `CHK("present", 1'b1, card_present)
    r(16'hFE05);
    `CHK("present bit", c | 8'h41, q)
    @(posedge clk) ins <= 1'b0;
    tk(2);
    `CHK("removed", 1'b0, card_present)
  endtask : t_det
  task automatic t_off();
    @(posedge clk) con <= 1'b0;
    w(16'hFE05, 8'h00);
    w(16'hFE0A, 8'h01);
    @(posedge clk) ins <= 1'b1;
    tk(4);
    r(16'hFE0A);
    `CHK("gated", 9'h000, {q, card_present})
    @(posedge clk) ins <= 1'b0;
  endtask : t_off
  task automatic t_filt();
    w(16'hFE05, 8'h80);
    w(16'hFE0A, 8'h03);
    w(16'hFE05, 8'hC0);
    @(posedge clk) ins <= 1'b1;
    tk((DB - 2) * 16);
    `CHK("bouncing", 1'b0, card_present)
    // one-cycle contact bounce restarts the count
    @(posedge clk) con <= 1'b1;
    @(posedge clk) con <= 1'b0;
    tk((DB - 1) * 16);
    `CHK("restarted", 1'b0, card_present)
    t0 = cyc;
    while (card_present !== 1'b1 && cyc - t0 < 2 * 16)
      tk(1);
    tk(1);
    `CHK("irq", 2'b11, {card_present, card_event_irq})
    w(16'hFE0A, 8'h01);
    tk(2);
    `CHK("masked", 1'b0, card_event_irq)
    @(posedge clk) ins <= 1'b0;
    w(16'hFE03, 8'h01);
    @(posedge clk) ins <= 1'b1;
    tk(3);
    `CHK("power down", 1'b1, card_present)
    @(posedge clk) ins <= 1'b0;
    w(16'hFE03, 8'h00);
  endtask : t_filt
  task automatic t_sup();
    w(16'hFE04, 8'h00);
    for (int c = 1; c < 4; c++)
    begin
      n = nd;
      w(16'hFE03, 8'(c << 6));
      tk(2);
      `CHK("code", {2'(c), 1'b1}, {supply_select, activation_go})
      w(16'hFE03, 8'h00);
      tk(2);
      `CHK("off now", n + 1, nd)
    end
    @(posedge clk) good <= 1'b1;
    w(16'hFE04, 8'h23);
    w(16'hFE03, 8'h40);
    t0 = cyc;
    while (activation_go !== 1'b1 && cyc - t0 < 40)
      tk(1);
    `CHK("wait", 1'b1, cyc - t0 > 16 && cyc - t0 < 28)
    n = nd;
    w(16'hFE03, 8'h00);
    t0 = cyc;
    while (nd == n && cyc - t0 < 40)
      tk(1);
    `CHK("off delay", 1'b1, cyc - t0 > 8 && nd == n + 1)
  endtask : t_sup
  task automatic t_bad();
    @(posedge clk) good <= 1'b0;
    w(16'hFE04, 8'h02);
    w(16'hFE03, 8'h80);
    tk(30);
    r(16'hFE0A);
    `CHK("abort", 4'h1, {supply_select, activation_go, q[0]})
    w(16'hFE03, 8'h40);
    tk(2);
    `CHK("refused", 2'b00, supply_select)
    w(16'hFE03, 8'h00);
    @(posedge clk) good <= 1'b1;
    @(posedge clk) lag <= 2'b00;
    w(16'hFE04, 8'hF0);
    w(16'hFE03, 8'hC0);
    tk(8);
    n = nd;
    @(posedge clk) fault <= 1'b1;
    tk(3);
    `CHK("fault", 1'b1, nd == n + 1 && supply_select == 2'b00)
    @(posedge clk) fault <= 1'b0;
    w(16'hFE03, 8'h00);
    w(16'hFE03, 8'h40);
    tk(8);
    n = nd;
    @(posedge clk) good <= 1'b0;
    tk(4);
    `CHK("supply loss", 1'b1, nd == n + 1 && supply_select == 2'b00)
    w(16'hFE03, 8'h00);
    w(16'hFE03, 8'h40);
    n = nd;
    @(posedge clk) ins <= 1'b1;
    tk(6 * 16);
    `CHK("card event", 1'b1, nd == n + 1 && supply_select == 2'b00)
    @(posedge clk) ins <= 1'b0;
  endtask : t_bad
  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    tk(4);
    t_regs();
    t_det(1'b0);
    t_det(1'b1);
    t_off();
    t_filt();
    t_sup();
    t_bad();
    print_verdict();
  end
endmodule : cst_top_bench

// ### bench/cst_top_sva.sv
`timescale 1ns/10ps
module cst_top_chk
  import cst_pkg::*;
#(
  parameter int DEBOUNCE_TICKS = 64
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic tick_32k,
  input wire logic tick_1k,
  input wire logic supply_ok,
  input wire logic supply_fault,
  input wire logic card_sense_pin,
  input wire logic [1:0] supply_select,
  input wire logic activation_go,
  input wire logic deactivate,
  input wire logic card_present,
  input wire logic card_event_irq,
  input wire logic pullup_on_n,
  input wire logic pulldown_on
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic [7:0] tmr, det, fcnt;
  logic [3:0] tcnt;
  logic pd, ion, raw, off;
  assign raw = det[6] && (card_sense_pin == det[3]);
  assign off = reg_wr && reg_addr == 16'hFE03 && reg_wdata[7:6] == 2'b00 && activation_go;
  // shadows of software settings, plus counters of slow ticks (tcnt) and filter ticks (fcnt)
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tmr <= 8'h0F;
      det <= 8'h00;
      pd <= 1'b0;
      ion <= 1'b0;
      tcnt <= 4'h0;
      fcnt <= 8'h00;
    end
    else
    begin
      if (reg_wr && reg_addr == 16'hFE04)
        tmr <= reg_wdata;
      if (reg_wr && reg_addr == 16'hFE05)
        det <= reg_wdata;
      if (reg_wr && reg_addr == 16'hFE03)
        pd <= reg_wdata[0];
      if (reg_wr && reg_addr == 16'hFE0A)
        ion <= reg_wdata[1];
      tcnt <= supply_select == 2'b00 ? 4'h0 : tcnt + 4'(tick_32k && !activation_go);
      // saturate so long insertions never wrap
      fcnt <= !raw ? 8'h00 : fcnt + 8'(tick_1k && fcnt != 8'hFF);
    end
  end
  sequence s_gone;
    !raw [*2];
  endsequence
  sequence s_held;
    (raw && (!det[7] || pd)) [*2];
  endsequence
  AST_WAIT: assert property (
    $rose(activation_go) && tmr[3:0] != 4'h0 |-> tcnt == tmr[3:0]) else $error("early go");
  AST_ABORT: assert property (
    tick_32k && !activation_go && supply_select != 2'b00 && !supply_ok && tmr[3:0] != 4'h0
    && tcnt + 4'h1 == tmr[3:0] |=> deactivate && supply_select == 2'b00) else $error("no abort");
  AST_NO_TMO: assert property (
    $rose(supply_select != 2'b00) && tmr[3:0] == 4'h0 |-> ##[0:1] activation_go)
    else $error("no go");
  AST_OFF_WAIT: assert property (
    off && tmr[7:4] != 4'h0 |=> !deactivate) else $error("off delay skipped");
  AST_OFF_NOW: assert property (
    off && tmr[7:4] == 4'h0 |=> deactivate) else $error("off late");
  AST_FAULT: assert property (
    $rose(supply_fault) && activation_go |-> ##[1:2] deactivate) else $error("fault late");
  AST_FILTER: assert property (
    $rose(card_present) && det[7] && !pd |-> fcnt >= DEBOUNCE_TICKS - 1) else $error("bounce");
  AST_GONE: assert property (
    s_gone |=> !card_present) else $error("removal late");
  AST_HELD: assert property (
    s_held |=> card_present) else $error("insert late");
  AST_PULLS: assert property (
    $stable(det) [*2] |-> pullup_on_n == det[2] && pulldown_on == det[1]) else $error("pulls");
  AST_EVENT: assert property (
    $changed(card_present) && ion && det[6] |=> card_event_irq) else $error("no event");
  AST_GATE: assert property (
    !ion && !$past(ion) |-> !card_event_irq) else $error("irq ungated");
endmodule : cst_top_chk

bind cst_top cst_top_chk #(.DEBOUNCE_TICKS(DEBOUNCE_TICKS)) cst_top_chk_inst (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .tick_32k(tick_32k), .tick_1k(tick_1k), .supply_ok(supply_ok), .supply_fault(supply_fault),
  .card_sense_pin(card_sense_pin), .supply_select(supply_select), .deactivate(deactivate),
  .activation_go(activation_go), .card_present(card_present), .pulldown_on(pulldown_on),
  .card_event_irq(card_event_irq), .pullup_on_n(pullup_on_n));

// ### verilog/cst_debounce.sv
`timescale 1ns/10ps
`include "cst_regs.svh"

module cst_debounce
  import cst_pkg::*;
#(
  parameter int DEBOUNCE_TICKS = `CST_DEBOUNCE_TICKS
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sense,
  input wire logic filter_on,
  input wire logic tick,
  output logic present
);

  generate
    if (DEBOUNCE_TICKS < 1 || DEBOUNCE_TICKS > 127)
    begin : g_bad_ticks
      $error("cst_debounce: DEBOUNCE_TICKS must be 1 to 127");
    end
  endgenerate

  localparam logic [6:0] LAST_TICK = 7'(DEBOUNCE_TICKS - 1);

  cst_filter_state_type s;
  cst_filter_state_type next_s;

  always_comb
  begin
    next_s = s;
    if (!sense)
    begin
      next_s.present = 1'b0;
      next_s.count = 7'h00;
    end
    else if (!filter_on)
    begin
      next_s.present = 1'b1;
    end
    else if (!s.present && tick)
    begin
      if (s.count == LAST_TICK)
      begin
        next_s.present = 1'b1;
      end
      else
      begin
        next_s.count = s.count + 7'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign present = s.present;

endmodule : cst_debounce

// ### verilog/cst_pkg.sv
package cst_pkg;

  typedef enum logic [1:0] {
    CST_IDLE,
    CST_WAIT_STABLE,
    CST_ACTIVE,
    CST_OFF_DELAY
  } cst_supply_state_type;

  typedef struct packed {
    logic [6:0] count;
    logic present;
  } cst_filter_state_type;

  typedef struct packed {
    logic [1:0] rst_sync;
    cst_supply_state_type supply_state;
    logic [1:0] supply_select;
    logic need_clear;
    logic power_down_bit;
    logic [3:0] count;
    logic [3:0] off_delay_count;
    logic [3:0] stable_wait_count;
    logic detect_filter_on;
    logic detect_on;
    logic detect_sense;
    logic pullup_on_n;
    logic pulldown_on;
    logic card_present;
    logic card_event;
    logic card_event_irq_on;
    logic card_event_irq;
    logic supply_ok_prev;
    logic activation_go;
    logic deactivate;
    logic [7:0] rdata;
  } cst_state_type;

endpackage : cst_pkg

// ### verilog/cst_regs.svh
`ifndef CST_REGS_SVH
`define CST_REGS_SVH

// register offsets on the 16-bit byte address port
`define CST_SUPPLY_CONTROL_ADDR 16'hFE03
`define CST_SUPPLY_TIMING_ADDR 16'hFE04
`define CST_CARD_DETECT_ADDR 16'hFE05
`define CST_CARD_EVENT_ADDR 16'hFE0A

// reset values
`define CST_SUPPLY_CONTROL_RESET 8'h00
`define CST_SUPPLY_TIMING_RESET 8'h0F
`define CST_CARD_DETECT_RESET 8'h00
`define CST_CARD_EVENT_RESET 8'h00

// supply_control fields
`define CST_SUPPLY_SELECT_HI 7
`define CST_SUPPLY_SELECT_LO 6
`define CST_SUPPLY_STABLE_BIT 3
`define CST_POWER_DOWN_BIT 0

// supply_timing_control fields
`define CST_OFF_DELAY_HI 7
`define CST_OFF_DELAY_LO 4
`define CST_STABLE_WAIT_HI 3
`define CST_STABLE_WAIT_LO 0

// card_detect_control fields
`define CST_DETECT_FILTER_ON_BIT 7
`define CST_DETECT_ON_BIT 6
`define CST_DETECT_SENSE_BIT 3
`define CST_PULLUP_ON_N_BIT 2
`define CST_PULLDOWN_ON_BIT 1
`define CST_CARD_PRESENT_BIT 0

// card_event_status fields
`define CST_CARD_EVENT_BIT 0
`define CST_CARD_EVENT_IRQ_ON_BIT 1

// timing: slow tick is one 32768 Hz period, filter tick is 1 ms
`define CST_FILTER_TICK_MS 1
`define CST_DEBOUNCE_MS 64
`define CST_DEBOUNCE_TICKS (`CST_DEBOUNCE_MS / `CST_FILTER_TICK_MS)

`endif

// ### verilog/cst_top.sv
`timescale 1ns/10ps
`include "cst_regs.svh"

module cst_top
  import cst_pkg::*;
#(
  parameter int DEBOUNCE_TICKS = `CST_DEBOUNCE_TICKS
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic tick_32k,
  input wire logic tick_1k,
  input wire logic supply_ok,
  input wire logic supply_fault,
  input wire logic card_sense_pin,
  output logic [1:0] supply_select,
  output logic activation_go,
  output logic deactivate,
  output logic card_present,
  output logic card_event_irq,
  output logic pullup_on_n,
  output logic pulldown_on
);

  cst_state_type s;
  cst_state_type next_s;
  logic rst_n;
  logic sense_qual;
  logic filter_on;
  logic filtered_present;

  assign rst_n = s.rst_sync[1];

  // sense only counts while detection is on
  // polarity select on the sense pin
  assign sense_qual = s.detect_on & (card_sense_pin == s.detect_sense);
  assign filter_on = s.detect_filter_on & ~s.power_down_bit;

  // filter runs on clk and the 1 kHz tick only
  cst_debounce #(
    .DEBOUNCE_TICKS(DEBOUNCE_TICKS)
  ) cst_debounce_inst (
    .clk(clk),
    .rst_n(rst_n),
    .sense(sense_qual),
    .filter_on(filter_on),
    .tick(tick_1k),
    .present(filtered_present)
  );

  logic wr_supply;
  logic wr_timing;
  logic wr_detect;
  logic wr_event;
  logic [1:0] new_select;
  logic card_change;
  logic supply_lost;
  logic emergency;
  logic abort;
  logic event_clear;

  always_comb
  begin
    next_s = s;
    next_s.rst_sync = {s.rst_sync[0], 1'b1};
    next_s.deactivate = 1'b0;
    next_s.rdata = 8'h00;
    abort = 1'b0;

    wr_supply = reg_wr && (reg_addr == `CST_SUPPLY_CONTROL_ADDR);
    wr_timing = reg_wr && (reg_addr == `CST_SUPPLY_TIMING_ADDR);
    wr_detect = reg_wr && (reg_addr == `CST_CARD_DETECT_ADDR);
    wr_event = reg_wr && (reg_addr == `CST_CARD_EVENT_ADDR);
    new_select = reg_wdata[`CST_SUPPLY_SELECT_HI:`CST_SUPPLY_SELECT_LO];

    // register writes
    if (wr_supply)
    begin
      next_s.power_down_bit = reg_wdata[`CST_POWER_DOWN_BIT];
    end
    if (wr_timing)
    begin
      next_s.off_delay_count = reg_wdata[`CST_OFF_DELAY_HI:`CST_OFF_DELAY_LO];
      next_s.stable_wait_count = reg_wdata[`CST_STABLE_WAIT_HI:`CST_STABLE_WAIT_LO];
    end
    if (wr_detect)
    begin
      next_s.detect_filter_on = reg_wdata[`CST_DETECT_FILTER_ON_BIT];
      next_s.detect_on = reg_wdata[`CST_DETECT_ON_BIT];
      next_s.detect_sense = reg_wdata[`CST_DETECT_SENSE_BIT];
      next_s.pullup_on_n = reg_wdata[`CST_PULLUP_ON_N_BIT];
      next_s.pulldown_on = reg_wdata[`CST_PULLDOWN_ON_BIT];
    end
    if (wr_event)
    begin
      next_s.card_event_irq_on = reg_wdata[`CST_CARD_EVENT_IRQ_ON_BIT];
    end

    // every change of presence while detection is on is an event
    card_change = s.detect_on && (filtered_present != s.card_present);
    next_s.card_present = s.detect_on & filtered_present;

    // falling supply_ok counts as supply loss
    next_s.supply_ok_prev = supply_ok;
    supply_lost = s.supply_ok_prev & ~supply_ok;
    emergency = card_change | supply_lost | supply_fault;

    unique case (s.supply_state)
      CST_IDLE:
      begin
        if (wr_supply && new_select == 2'b00)
        begin
          next_s.need_clear = 1'b0;
        end
        else if (wr_supply && !s.need_clear)
        begin
          next_s.supply_select = new_select;
          next_s.count = s.stable_wait_count;
          // zero code means no timeout check
          if (s.stable_wait_count == 4'h0)
          begin
            next_s.supply_state = CST_ACTIVE;
            next_s.activation_go = 1'b1;
          end
          else
          begin
            next_s.supply_state = CST_WAIT_STABLE;
          end
        end
      end
      CST_WAIT_STABLE:
      begin
        if (tick_32k)
        begin
          if (s.count == 4'h1)
          begin
            if (supply_ok)
            begin
              next_s.supply_state = CST_ACTIVE;
              next_s.activation_go = 1'b1;
            end
            else
            begin
              abort = 1'b1;
            end
          end
          else
          begin
            next_s.count = s.count - 4'h1;
          end
        end
      end
      CST_ACTIVE:
      begin
        // voltage changes while powered are ignored
        if (wr_supply && new_select == 2'b00)
        begin
          next_s.supply_select = 2'b00;
          next_s.activation_go = 1'b0;
          if (s.off_delay_count == 4'h0)
          begin
            next_s.deactivate = 1'b1;
            next_s.supply_state = CST_IDLE;
          end
          else
          begin
            next_s.count = s.off_delay_count;
            next_s.supply_state = CST_OFF_DELAY;
          end
        end
      end
      CST_OFF_DELAY:
      begin
        // count the off-delay in slow ticks
        if (tick_32k)
        begin
          if (s.count == 4'h1)
          begin
            next_s.deactivate = 1'b1;
            next_s.supply_state = CST_IDLE;
          end
          else
          begin
            next_s.count = s.count - 4'h1;
          end
        end
      end
    endcase

    // software abandoning a pending activation
    if (s.supply_state == CST_WAIT_STABLE && wr_supply && new_select == 2'b00 && !abort)
    begin
      next_s.supply_select = 2'b00;
      next_s.deactivate = 1'b1;
      next_s.supply_state = CST_IDLE;
    end

    // timeout abort clears select and deactivates
    // hardware clear demands a zero write first
    if (abort || (emergency && s.supply_state != CST_IDLE))
    begin
      next_s.supply_select = 2'b00;
      next_s.activation_go = 1'b0;
      next_s.deactivate = 1'b1;
      next_s.need_clear = 1'b1;
      next_s.supply_state = CST_IDLE;
    end

    // timeout raises the card event too
    // set beats a same-cycle clear
    event_clear = wr_event && reg_wdata[`CST_CARD_EVENT_BIT];
    next_s.card_event = (s.card_event & ~event_clear) | card_change | abort;
    next_s.card_event_irq = next_s.card_event & next_s.card_event_irq_on;

    // read data valid in the following cycle only
    if (reg_rd)
    begin
      unique case (reg_addr)
        `CST_SUPPLY_CONTROL_ADDR:
        begin
          next_s.rdata = {s.supply_select, 1'b0, 1'b0, s.supply_ok_prev, 2'b00,
                          s.power_down_bit};
        end
        `CST_SUPPLY_TIMING_ADDR:
        begin
          next_s.rdata = {s.off_delay_count, s.stable_wait_count};
        end
        `CST_CARD_DETECT_ADDR:
        begin
          next_s.rdata = {s.detect_filter_on, s.detect_on, 2'b00, s.detect_sense,
                          s.pullup_on_n, s.pulldown_on, s.card_present};
        end
        `CST_CARD_EVENT_ADDR:
        begin
          next_s.rdata = {6'h00, s.card_event_irq_on, s.card_event};
        end
        default:
        begin
          next_s.rdata = 8'h00;
        end
      endcase
    end
  end

  // reset sync stage sits in the state word; async assert, sync release
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s <= '0;
      s.supply_state <= CST_IDLE;
      s.off_delay_count <= 4'(`CST_SUPPLY_TIMING_RESET >> `CST_OFF_DELAY_LO);
      s.stable_wait_count <= 4'(`CST_SUPPLY_TIMING_RESET);
    end
    else if (!s.rst_sync[1])
    begin
      s.rst_sync <= next_s.rst_sync;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign supply_select = s.supply_select;
  assign activation_go = s.activation_go;
  assign deactivate = s.deactivate;
  assign card_present = s.card_present;
  assign card_event_irq = s.card_event_irq;
  assign pullup_on_n = s.pullup_on_n;
  assign pulldown_on = s.pulldown_on;

endmodule : cst_top

// ### verilog/placeholder_none.sv
`timescale 1ns/10ps
